// ==== ltps_pkg.sv ====
/*
 * Constants for the live-time preset-stop block: timing, channel limits,
 * register offsets and field positions.
 * Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package ltps_pkg;
	localparam int CLK_MHZ = 40; // System clock rate in MHz
	localparam int NORM_PERIOD_US = 6000; // 10,000 pulses per minute
	localparam int ALT_PERIOD_US = 1000; // 1000 pulses per second
	localparam int STORE_US = 18; // Clock-channel store time
	localparam int NORM_CYC = NORM_PERIOD_US * CLK_MHZ; // Normal period in cycles
	localparam int ALT_CYC = ALT_PERIOD_US * CLK_MHZ; // Alternate period in cycles
	localparam int STORE_CYC = STORE_US * CLK_MHZ; // Store cycle length
	localparam int CW = 20; // Channel count width
	localparam logic [19:0] CH_MAX = 20'hF4240; // One million counts
	localparam logic [19:0] PRESET_MIN = 20'h02710; // 10,000 counts
	localparam logic [19:0] CNT_THOUSAND = 20'h003E8; // Preset table unit
	localparam int AW = 8; // Register address width
	localparam logic [7:0] CTRL_OFS = 8'h00; // Control
	localparam logic [7:0] PRESET_OFS = 8'h04; // Preset code
	localparam logic [7:0] STAT_OFS = 8'h08; // Live status
	localparam logic [7:0] CLKCH_OFS = 8'h0C; // Clock-channel count
	localparam logic [7:0] ISTAT_OFS = 8'h10; // Sticky event bits
	localparam logic [7:0] IMASK_OFS = 8'h14; // Event mask
	localparam int CTRL_RUN = 0; // Write 1 starts analysis
	localparam int CTRL_STOP = 1; // Write 1 stops analysis
	localparam int CTRL_SUB = 2; // Subtract mode
	localparam int CTRL_ALT = 3; // Alternate clock rate
	localparam int CTRL_HARD = 4; // Hard-stop position held
	localparam int CTRL_ERASE = 5; // Write 1 empties the clock channel
	localparam int EV_PRESET = 0; // Preset reached
	localparam int EV_ZERO = 1; // Channel emptied in subtract mode
	localparam int EV_TAGACC = 2; // Tagged pulse accepted
	localparam int EV_TAGREJ = 3; // Tagged pulse rejected
	localparam int EVW = 4; // Number of events
	localparam logic [3:0] PRESET_RST = 4'h0; // Preset code after reset
	localparam logic [1:0] RESP_OKAY = 2'h0; // AXI OKAY
	localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR
endpackage : ltps_pkg

// ==== ltps_chan_mem.sv ====
/*
 * Channel count memory with one write port and one registered read port.
 * Assumes write and read on the same clock; read data lag one edge.
 */
`timescale 1ns/1ps
module ltps_chan_mem #(
	parameter int DW = 20, // Word width
	parameter int AWID = 2 // Address width
) (
	input wire logic clk, // System clock
	input wire logic we, // Write strobe
	input wire logic [AWID-1:0] waddr, // Write address
	input wire logic [DW-1:0] wdata, // Write data
	input wire logic [AWID-1:0] raddr, // Read address
	output logic [DW-1:0] rdata // Registered read data
);
	logic [DW-1:0] mem [0:(1<<AWID)-1]; // Channel storage

	// Write port; contents are not reset, software erases them
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read port, registered so the result comes from a flop
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : ltps_chan_mem

// ==== ltps_top.sv ====
/*
 * Live-time clock, tagged-pulse acceptance, clock-channel store and
 * preset/subtract stop monitor, with an AXI4-Lite register slave.
 * Assumes converter busy, gate-reopen and detector pulse arrive as
 * asynchronous pins; the converter itself lies outside.
 */
// How it works
// - Reject pulses while linear gate reopens.
// - Normal rate: 10,000 accepted pulses per minute.
// - Selector gives 1000 pulses per second.
// - Continuous compare halts analysis at preset.
// - Preset at least 10,000; largest 1,000,000.
// - Preset digits powers of two, plus 1000.
// - Accepted clock pulse counts in channel zero.
// - Manual stop leaves clock channel intact.
// - Subtract mode stops when channel empties.
// - Channels saturate at one million counts.
// - Clock pulse enters as tagged input pulse.
// - Accepted tag starts store, aborts analysis.
// - Tag acceptance identical to real pulses.
// - Store lasts 18 us, below period.
// - Hard stop forces scalers, control off.
`timescale 1ns/1ps
module ltps_top #(
	parameter int NORM_PERIOD = ltps_pkg::NORM_CYC, // Normal tag period
	parameter int ALT_PERIOD = ltps_pkg::ALT_CYC // Alternate tag period
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic conv_busy, // Converter busy pin
	input wire logic gate_reopen, // Linear gate reopening pin
	input wire logic det_pulse, // Detector pulse pin
	output logic conv_start, // Real pulse accepted, one cycle
	output logic tag_abort, // Tagged pulse accepted, abort analysis
	output logic analyzing, // Analysis running
	output logic irq // Level interrupt
);
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_HOLD} ltps_st_t;

	// Saturating step of the clock channel
	function automatic logic [19:0] ltps_step(input logic [19:0] c, input logic sub);
		if (sub) begin
			ltps_step = (c == 20'h00000) ? c : c - 20'h00001;
		end else begin
			ltps_step = (c >= ltps_pkg::CH_MAX) ? ltps_pkg::CH_MAX : c + 20'h00001;
		end
	endfunction : ltps_step

	// Preset table in thousands of counts
	function automatic logic [19:0] ltps_preset(input logic [3:0] code);
		logic [9:0] k;
		k = 10'h000;
		case (code)
			4'h1: k = 10'h014;
			4'h2: k = 10'h028;
			4'h3: k = 10'h050;
			4'h4: k = 10'h064;
			4'h5: k = 10'h0C8;
			4'h6: k = 10'h190;
			4'h7: k = 10'h320;
			4'h8: k = 10'h3E8;
			default: k = 10'h00A;
		endcase
		ltps_preset = 20'(k * ltps_pkg::CNT_THOUSAND);
	endfunction : ltps_preset

	logic [2:0] busy_sy, reopen_sy, det_sy; // Pin synchronisers, bit 2 is edge history
	ltps_st_t st_reg; // Store state
	logic [9:0] hold_reg; // Store hold counter
	logic [21:0] div_reg; // Tag period divider
	logic analyzing_reg; // Analysis running
	logic sub_reg, alt_reg, hard_reg; // Stored mode bits
	logic [3:0] preset_code_reg; // Preset selector
	localparam int EVW = ltps_pkg::EVW; // Event count, declared before its first use
	logic [EVW-1:0] ist_reg, imask_reg; // Sticky events and mask
	logic [19:0] ch_rdata; // Clock channel as stored
	logic [19:0] preset_cnt; // Active preset in counts
	logic tag_tick, open_now, tag_acc, tag_rej, det_acc; // Acceptance terms
	logic wr_go, erase_go, run_go, stop_go, preset_hit, zero_hit; // Control events
	logic mem_we; // Channel write strobe
	logic [19:0] mem_wdata; // Channel write data
	logic aw_full, w_full; // Write halves captured
	logic [7:0] aw_addr; // Captured write address
	logic [31:0] w_data; // Captured write data
	logic [3:0] w_strb; // Captured strobes
	logic [EVW-1:0] ev; // Events this cycle

	// Two flip-flops on every pin before any logic looks at it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_sy <= 3'h0;
			reopen_sy <= 3'h0;
			det_sy <= 3'h0;
		end else begin
			busy_sy <= {busy_sy[1:0], conv_busy};
			reopen_sy <= {reopen_sy[1:0], gate_reopen};
			det_sy <= {det_sy[1:0], det_pulse};
		end
	end

	// period divider, normal or alternate rate
	always_ff @(posedge aclk) begin
		if (!aresetn || hard_reg || tag_tick) begin
			div_reg <= 22'h000000;
		end else begin
			div_reg <= div_reg + 22'h000001;
		end
	end
	// selector switches the period; >= so a switch to the short one never runs on to wrap
	assign tag_tick = alt_reg ? (div_reg >= 22'(ALT_PERIOD - 1)) : (div_reg >= 22'(NORM_PERIOD - 1));

	// one acceptance term for tagged and real pulses
	// gate reopening counts as dead even when not busy
	assign open_now = analyzing_reg && !busy_sy[1] && !reopen_sy[1] && st_reg == ST_IDLE;
	// the tick enters as a tagged input pulse
	assign tag_acc = tag_tick && open_now;
	assign tag_rej = tag_tick && !open_now && analyzing_reg;
	// A real pulse coinciding with a tag loses to it
	assign det_acc = det_sy[1] && !det_sy[2] && open_now && !tag_tick;

	// Acceptance outputs, one cycle each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_start <= 1'b0;
			tag_abort <= 1'b0;
		end else begin
			conv_start <= det_acc;
			tag_abort <= tag_acc;
		end
	end

	// Store cycle: one write edge then a hold, STORE_CYC cycles in all
	always_ff @(posedge aclk) begin
		if (!aresetn || hard_reg) begin
			st_reg <= ST_IDLE;
			hold_reg <= 10'h000;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (tag_acc) begin
						st_reg <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					// fixed store time, far below the tag period
					st_reg <= ST_HOLD;
					hold_reg <= 10'(ltps_pkg::STORE_CYC - 2);
				end
				ST_HOLD: begin
					if (hold_reg == 10'h000) begin
						st_reg <= ST_IDLE;
					end else begin
						hold_reg <= hold_reg - 10'h001;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// the clock lives in channel zero
	// subtract mode counts down; saturating either way
	assign mem_we = (st_reg == ST_WRITE) || erase_go;
	assign mem_wdata = erase_go ? 20'h00000 : ltps_step(ch_rdata, sub_reg);

	ltps_chan_mem #(.DW(ltps_pkg::CW), .AWID(2)) u_mem (
		.clk(aclk),
		.we(mem_we),
		.waddr(2'h0),
		.wdata(mem_wdata),
		.raddr(2'h0),
		.rdata(ch_rdata)
	);

	// never below the minimum; table of recognised values
	assign preset_cnt = (ltps_preset(preset_code_reg) < ltps_pkg::PRESET_MIN) ?
		ltps_pkg::PRESET_MIN : ltps_preset(preset_code_reg);
	// compare only while idle, when the channel word has settled
	assign preset_hit = analyzing_reg && st_reg == ST_IDLE && !sub_reg && ch_rdata >= preset_cnt;
	// subtract run ends on an empty channel
	assign zero_hit = analyzing_reg && st_reg == ST_IDLE && sub_reg && ch_rdata == 20'h00000;

	// Register write decode; both halves must be captured first
	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign run_go = wr_go && aw_addr == ltps_pkg::CTRL_OFS && w_strb[0] && w_data[ltps_pkg::CTRL_RUN]
		&& !w_data[ltps_pkg::CTRL_HARD];
	assign stop_go = wr_go && aw_addr == ltps_pkg::CTRL_OFS && w_strb[0] && w_data[ltps_pkg::CTRL_STOP];
	// Erasing only while stopped so a store cannot collide with it
	assign erase_go = wr_go && aw_addr == ltps_pkg::CTRL_OFS && w_strb[0] && w_data[ltps_pkg::CTRL_ERASE]
		&& !analyzing_reg && st_reg == ST_IDLE;

	// Run state
	always_ff @(posedge aclk) begin
		// hard stop keeps the control circuits off
		if (!aresetn || hard_reg) begin
			analyzing_reg <= 1'b0;
		end else if (stop_go || preset_hit || zero_hit) begin
			// a manual stop touches nothing but the run flag
			analyzing_reg <= 1'b0;
		end else if (run_go) begin
			analyzing_reg <= 1'b1;
		end
	end

	// Stored control fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sub_reg <= 1'b0;
			alt_reg <= 1'b0;
			hard_reg <= 1'b0;
			preset_code_reg <= ltps_pkg::PRESET_RST;
			imask_reg <= '0;
		end else if (wr_go && w_strb[0]) begin
			if (aw_addr == ltps_pkg::CTRL_OFS) begin
				sub_reg <= w_data[ltps_pkg::CTRL_SUB];
				alt_reg <= w_data[ltps_pkg::CTRL_ALT];
				hard_reg <= w_data[ltps_pkg::CTRL_HARD];
			end
			if (aw_addr == ltps_pkg::PRESET_OFS) begin
				preset_code_reg <= w_data[3:0];
			end
			if (aw_addr == ltps_pkg::IMASK_OFS) begin
				imask_reg <= w_data[EVW-1:0];
			end
		end
	end

	// Sticky events; a new event wins over a same-cycle clear
	assign ev = {tag_rej, tag_acc, zero_hit, preset_hit};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_reg <= '0;
		end else if (wr_go && w_strb[0] && aw_addr == ltps_pkg::ISTAT_OFS) begin
			ist_reg <= (ist_reg & ~w_data[EVW-1:0]) | ev;
		end else begin
			ist_reg <= ist_reg | ev;
		end
	end

	// Interrupt and run outputs from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
			analyzing <= 1'b0;
		end else begin
			irq <= |(ist_reg & imask_reg);
			analyzing <= analyzing_reg;
		end
	end

	// AXI write channel: capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ltps_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready) && !wr_go;
			s_axi_wready <= !w_full && !(s_axi_wvalid && s_axi_wready) && !wr_go;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == ltps_pkg::STAT_OFS || aw_addr == ltps_pkg::CLKCH_OFS ||
					aw_addr > ltps_pkg::IMASK_OFS || aw_addr[1:0] != 2'h0) ?
					ltps_pkg::RESP_SLVERR : ltps_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ltps_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ltps_pkg::RESP_OKAY;
				case (s_axi_araddr)
					ltps_pkg::CTRL_OFS: s_axi_rdata <= {27'h0, hard_reg, alt_reg, sub_reg, 2'h0};
					ltps_pkg::PRESET_OFS: s_axi_rdata <= {28'h0, preset_code_reg};
					ltps_pkg::STAT_OFS: s_axi_rdata <= {30'h0, st_reg != ST_IDLE, analyzing_reg};
					ltps_pkg::CLKCH_OFS: s_axi_rdata <= {12'h000, ch_rdata};
					ltps_pkg::ISTAT_OFS: s_axi_rdata <= {28'h0, ist_reg};
					ltps_pkg::IMASK_OFS: s_axi_rdata <= {28'h0, imask_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= ltps_pkg::RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Helper: length of the last busy stretch of the store
	logic [9:0] busy_len;
	always_ff @(posedge aclk) begin
		if (!aresetn || st_reg == ST_IDLE) begin
			busy_len <= 10'h000;
		end else begin
			busy_len <= busy_len + 10'h001;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_reject_reopen: assert property (reopen_sy[1] |-> !tag_acc && !det_acc)
		else $error("pulse accepted while gate reopening");
	chk_tag_period: assert property (tag_tick |=> div_reg == 22'h000000 ##1 !tag_tick)
		else $error("tag period counter misbehaves");
	chk_alt_rate: assert property (alt_reg && !hard_reg && div_reg == 22'(ALT_PERIOD - 1) |-> tag_tick)
		else $error("alternate rate tick missing");
	chk_preset_halt: assert property (preset_hit && !hard_reg |=> !analyzing_reg ##1 !analyzing)
		else $error("preset did not halt analysis");
	chk_preset_floor: assert property (preset_cnt >= ltps_pkg::PRESET_MIN && preset_cnt <= ltps_pkg::CH_MAX)
		else $error("preset outside allowed range");
	chk_tag_store: assert property (tag_acc && !hard_reg |=> st_reg == ST_WRITE && tag_abort)
		else $error("accepted tag did not start store");
	chk_store_len: assert property ($fell(st_reg != ST_IDLE) && !$past(hard_reg)
		|-> $past(busy_len) == 10'(ltps_pkg::STORE_CYC - 1))
		else $error("store cycle length wrong");
	chk_sat_limit: assert property (mem_we |-> mem_wdata <= ltps_pkg::CH_MAX)
		else $error("channel count above one million");
	chk_sub_step: assert property (st_reg == ST_WRITE && sub_reg && ch_rdata != 20'h00000
		|-> mem_wdata == ch_rdata - 20'h00001)
		else $error("subtract store did not decrement");
	chk_zero_halt: assert property (zero_hit && !hard_reg |=> !analyzing_reg)
		else $error("empty channel did not stop subtract run");
	chk_hard_hold: assert property (hard_reg |=> !analyzing_reg && st_reg == ST_IDLE && div_reg == 22'h000000)
		else $error("hard stop did not hold control off");
endmodule : ltps_top

// ==== ltps_conv_model.sv ====
/*
 * Converter-side model: goes busy after each accepted real pulse, then
 * reopens its linear gate before it is live again.
 * Assumes the block's single clock; the bench may hold either pin high.
 */
`timescale 1ns/1ps
module ltps_conv_model #(
	parameter int BUSY_CYC = 30, // Analysis time in cycles
	parameter int REOPEN_CYC = 12 // Gate reopening time in cycles
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic conv_start, // Real pulse accepted
	input wire logic hold_busy, // Bench forces busy
	input wire logic hold_reopen, // Bench forces reopening
	output logic conv_busy, // Busy pin
	output logic gate_reopen // Reopening pin
);
	int cnt; // Cycles left in the dead span

	// aborted tags
	// Only a real start opens a dead span; an aborted tag costs nothing here
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt <= 0;
		else if (conv_start)
			cnt <= BUSY_CYC + REOPEN_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end

	// reopen is dead
	// Tail of the span is gate reopening: not busy, yet still rejecting
	assign conv_busy = hold_busy | (cnt > REOPEN_CYC);
	assign gate_reopen = hold_reopen | (cnt > 0 && cnt <= REOPEN_CYC);
endmodule : ltps_conv_model

// ==== live_time_preset_stop_tb_top.sv ====
/*
 * Self-checking bench for the live-time preset-stop block.
 * Assumes short tag periods set by parameter; converter model on the pins.
 */
`timescale 1ns/1ps
module live_time_preset_stop_tb_top;
	localparam int NP = 2000; // Normal tag period, shortened
	localparam int AP = 1000; // Alternate tag period, shortened
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conv_busy, gate_reopen, det_pulse;
	logic conv_start, tag_abort, analyzing, irq, hold_busy, hold_reopen; // Pins and bench holds
	logic [7:0] s_axi_awaddr, s_axi_araddr; // Byte addresses
	logic [31:0] s_axi_wdata, s_axi_rdata; // Bus data
	logic [3:0] s_axi_wstrb; // Write strobes
	logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
	logic [5:0] dead_hist = 6'h00; // Recent dead state of the pins
	int errors, total_checks, seed, n0, s0, k, i;
	int cyc = 0, n_tag = 0, n_start = 0, last_tag = 0, gap = 0; // Written only by the monitor

	ltps_top #(.NORM_PERIOD(NP), .ALT_PERIOD(AP)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_busy(conv_busy),
		.gate_reopen(gate_reopen), .det_pulse(det_pulse), .conv_start(conv_start),
		.tag_abort(tag_abort), .analyzing(analyzing), .irq(irq));

	ltps_conv_model conv (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start), .hold_busy(hold_busy),
		.hold_reopen(hold_reopen), .conv_busy(conv_busy), .gate_reopen(gate_reopen));

	// Free-running 40 MHz clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Compares one value; an unknown never matches
	task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, got);
		end
	endtask : check_val

	// Write with address and data offered together, then the response
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (!s_axi_bready)
				s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
		s_axi_bready <= 1'b0;
		check_val("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask : axi_write

	// Read one word and compare data and response
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (!s_axi_rready)
				s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
		s_axi_rready <= 1'b0;
		check_val(name, exp, s_axi_rdata);
		check_val("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask : rd_chk

	task automatic cycles(input int n);
		repeat (n) @(posedge aclk);
	endtask : cycles

	// Waits for n more accepted tags; the watchdog bounds the wait
	task automatic wait_tags(input int n);
		int t;
		t = n_tag + n;
		while (n_tag < t)
			@(posedge aclk);
	endtask : wait_tags

	task results;
		$display("errors %0d, checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	// Counts tags and real starts; an acceptance after a long dead stretch is wrong
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		dead_hist <= {dead_hist[4:0], conv_busy | gate_reopen};
		if (tag_abort === 1'b1) begin
			gap <= cyc - last_tag;
			last_tag <= cyc;
			n_tag <= n_tag + 1;
		end
		if (conv_start === 1'b1)
			n_start <= n_start + 1;
		if ((tag_abort === 1'b1 || conv_start === 1'b1) && dead_hist == 6'h3F)
			check_val("accept_while_dead", 32'h0, 32'h1);
		if (tag_abort === 1'b1 && conv_start === 1'b1)
			check_val("start_with_tag", 32'h0, 32'h1);
	end

	// Watchdog: the whole run needs about 52k cycles
	initial begin
		cycles(90000);
		errors++;
		$display("unexpected timeout: expected finish, seen hang");
		results();
	end

	// Main sequence
	initial begin
		seed = 32'h69D4;
		{errors, total_checks} = '0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{det_pulse, hold_busy, hold_reopen, s_axi_wstrb} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		cycles(8);
		aresetn <= 1'b1;
		cycles(2);
		check_val("irq", 32'h0, {31'h0, irq});
		rd_chk("ctrl", ltps_pkg::CTRL_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		rd_chk("preset", ltps_pkg::PRESET_OFS, {28'h0, ltps_pkg::PRESET_RST}, ltps_pkg::RESP_OKAY);
		rd_chk("status", ltps_pkg::STAT_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		rd_chk("imask", ltps_pkg::IMASK_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		rd_chk("unmapped", 8'h18, 32'h0, ltps_pkg::RESP_SLVERR);
		axi_write(ltps_pkg::CLKCH_OFS, 32'h0, ltps_pkg::RESP_SLVERR);
		// Every preset code, then back to the shortest
		for (i = 0; i < 16; i++) begin
			axi_write(ltps_pkg::PRESET_OFS, i, ltps_pkg::RESP_OKAY);
			rd_chk("preset", ltps_pkg::PRESET_OFS, i, ltps_pkg::RESP_OKAY);
		end
		axi_write(ltps_pkg::PRESET_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_ERASE, ltps_pkg::RESP_OKAY);
		rd_chk("clkch", ltps_pkg::CLKCH_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		// Run with no dead time: every tag accepted at the set rate
		axi_write(ltps_pkg::IMASK_OFS, 32'h1 << ltps_pkg::EV_TAGACC, ltps_pkg::RESP_OKAY);
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_RUN, ltps_pkg::RESP_OKAY);
		n0 = n_tag;
		wait_tags(1);
		rd_chk("status", ltps_pkg::STAT_OFS, 32'h3, ltps_pkg::RESP_OKAY);
		wait_tags(2);
		check_val("tag_gap", NP, gap);
		check_val("irq", 32'h1, {31'h0, irq});
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_ALT, ltps_pkg::RESP_OKAY);
		wait_tags(2);
		check_val("tag_gap", AP, gap);
		axi_write(ltps_pkg::IMASK_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		cycles(3);
		check_val("irq", 32'h0, {31'h0, irq});
		// Manual stop keeps the count
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_STOP, ltps_pkg::RESP_OKAY);
		cycles(3);
		check_val("analyzing", 32'h0, {31'h0, analyzing});
		k = n_tag - n0;
		cycles(800);
		rd_chk("clkch", ltps_pkg::CLKCH_OFS, k, ltps_pkg::RESP_OKAY);
		cycles(NP);
		rd_chk("clkch", ltps_pkg::CLKCH_OFS, k, ltps_pkg::RESP_OKAY);
		// Subtract run counts the channel down and stops at zero
		axi_write(ltps_pkg::ISTAT_OFS, 32'hF, ltps_pkg::RESP_OKAY);
		axi_write(ltps_pkg::CTRL_OFS, 32'h5, ltps_pkg::RESP_OKAY);
		n0 = n_tag;
		cycles(3);
		while (analyzing === 1'b1)
			@(posedge aclk);
		check_val("sub_tags", k, n_tag - n0);
		rd_chk("clkch", ltps_pkg::CLKCH_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		rd_chk("istat", ltps_pkg::ISTAT_OFS, 32'h6, ltps_pkg::RESP_OKAY);
		// Held reopening, then held busy: every tag refused
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_ERASE, ltps_pkg::RESP_OKAY);
		axi_write(ltps_pkg::ISTAT_OFS, 32'hF, ltps_pkg::RESP_OKAY);
		for (i = 0; i < 2; i++) begin
			hold_reopen <= (i == 0);
			hold_busy <= (i == 1);
			cycles(4);
			n0 = n_tag;
			axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_RUN, ltps_pkg::RESP_OKAY);
			cycles(2 * NP + 50);
			check_val("dead_tags", n0, n_tag);
			axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_STOP, ltps_pkg::RESP_OKAY);
		end
		rd_chk("istat", ltps_pkg::ISTAT_OFS, 32'h8, ltps_pkg::RESP_OKAY);
		hold_busy <= 1'b0;
		// Random detector pulses compete with the tags
		n0 = n_tag;
		s0 = n_start;
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_RUN, ltps_pkg::RESP_OKAY);
		repeat (10 * NP) begin
			@(posedge aclk);
			det_pulse <= (($random(seed) & 63) == 0);
		end
		det_pulse <= 1'b0;
		axi_write(ltps_pkg::CTRL_OFS, 32'h1 << ltps_pkg::CTRL_STOP, ltps_pkg::RESP_OKAY);
		cycles(800);
		rd_chk("clkch", ltps_pkg::CLKCH_OFS, n_tag - n0, ltps_pkg::RESP_OKAY);
		check_val("real_starts", 32'h1, {31'h0, n_start > s0});
		// Hard stop holds everything off, start included
		axi_write(ltps_pkg::CTRL_OFS, 32'h11, ltps_pkg::RESP_OKAY);
		n0 = n_tag;
		cycles(NP + 20);
		check_val("analyzing", 32'h0, {31'h0, analyzing});
		check_val("hard_tags", n0, n_tag);
		rd_chk("ctrl", ltps_pkg::CTRL_OFS, 32'h10, ltps_pkg::RESP_OKAY);
		axi_write(ltps_pkg::CTRL_OFS, 32'h0, ltps_pkg::RESP_OKAY);
		results();
	end
endmodule : live_time_preset_stop_tb_top
